// File: rtl/cgr_pkg.sv
package cgr_pkg;

  localparam int          NUM_BYTES     = 17;
  localparam logic [7:0]  ADDR_WRITE    = 8'hd2;
  localparam logic [7:0]  ADDR_READ     = 8'hd3;

  localparam logic [7:0]  REG_FREQ_SPREAD   = 8'h00;
  localparam logic [7:0]  REG_BUS_OE        = 8'h01;
  localparam logic [7:0]  REG_MISC_OE       = 8'h02;
  localparam logic [7:0]  REG_SRC_CTRL      = 8'h03;
  localparam logic [7:0]  REG_USB_DRIVE     = 8'h04;
  localparam logic [7:0]  REG_SRC_FREQ      = 8'h05;
  localparam logic [7:0]  REG_PART_ID       = 8'h06;
  localparam logic [7:0]  REG_MAKER_REV     = 8'h07;
  localparam logic [7:0]  REG_READ_LEN      = 8'h08;
  localparam logic [7:0]  REG_SPARE         = 8'h09;
  localparam logic [7:0]  REG_DIV_GATE      = 8'h0a;
  localparam logic [7:0]  REG_CPU_DIV_HIGH  = 8'h0b;
  localparam logic [7:0]  REG_CPU_N_LOW     = 8'h0c;
  localparam logic [7:0]  REG_CPU_SPR_LOW   = 8'h0d;
  localparam logic [7:0]  REG_CPU_SPR_HIGH  = 8'h0e;
  localparam logic [7:0]  REG_SRC_DIV_HIGH  = 8'h0f;
  localparam logic [7:0]  REG_SRC_N_LOW     = 8'h10;

  localparam int          BIT_SELECT_ORIGIN = 7;
  localparam int          BIT_CPU_SPREAD    = 6;
  localparam int          BIT_SRC_SPREAD    = 5;
  localparam int          BIT_SRC_PD_MODE   = 1;
  localparam int          BIT_SRC_ENABLE    = 0;
  localparam int          BIT_MN_ENABLE     = 7;
  localparam int          BIT_N_DIV8        = 7;
  localparam int          BIT_FEEDBACK_DIVIDER_MSB        = 6;

  localparam logic [7:0]  RST_FREQ_SPREAD   = 8'h00;
  localparam logic [7:0]  RST_OUTPUT_ON     = 8'hff;
  localparam logic [7:0]  RST_SRC_CTRL      = 8'h01;
  localparam logic [7:0]  RST_READ_LEN      = 8'h09;
  localparam logic [7:0]  RST_ZERO          = 8'h00;
  localparam logic [7:0]  MASK_ALL          = 8'hff;
  localparam logic [7:0]  MASK_NONE         = 8'h00;
  localparam logic [7:0]  MASK_SPREAD_HIGH  = 8'h7f;

  localparam logic [10:0] N_OFFSET          = 11'h008;
  localparam logic [6:0]  M_OFFSET          = 7'h02;
  localparam logic [1:0]  STRAP_SETTLE      = 2'h3;

  // divider preload table per 3-bit selection: {n[9:0], m[5:0]}
  localparam logic [15:0] CPU_ROM [8] = '{
    16'h0000, 16'h0000, 16'h2ccc, 16'h36cc,
    16'h18cc, 16'h1fcc, 16'h278c, 16'h2f8c};
  localparam logic [15:0] SRC_ROM [8] = '{
    16'h0000, 16'h0000, 16'h144c, 16'h144c,
    16'h144c, 16'h144c, 16'h144c, 16'h144c};

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_RX     = 5'b00010,
    ST_RX_ACK = 5'b00100,
    ST_TX     = 5'b01000,
    ST_TX_ACK = 5'b10000
  } cgr_state_t;

  typedef enum logic [3:0] {
    PH_ADDR  = 4'b0001,
    PH_INDEX = 4'b0010,
    PH_COUNT = 4'b0100,
    PH_DATA  = 4'b1000
  } cgr_phase_t;

endpackage

// File: rtl/cgr_smbus_regs.sv
// Behaviour
// RULE_01: select origin bit picks straps or register code
// RULE_02: spread bits per PLL, spread pin forces both
// RULE_03: bytes 1, 2 enable outputs, reset enabled
// RULE_04: serial pair powerdown drive or float
// RULE_05: serial pair enable, cleared means floating
// RULE_06: byte 4 low bits set usb strength
// RULE_07: byte 5 bits 3:2 serial frequency code
// RULE_08: byte 6 read-only part code
// RULE_09: byte 7 read-only revision and maker codes
// RULE_10: byte 8 block read length, resets nine
// RULE_11: byte 10 bit 7 gates programmed dividers
// RULE_12: processor divider fields in bytes 11, 12
// RULE_13: vco equals reference times (N+8)/(M+2)
// RULE_14: dividers preload from selection table at powerup
// RULE_15: fifteen-bit processor spread code, bytes 13, 14
// RULE_16: byte 15 serial divider high bits
// RULE_17: byte 16 serial divider N low bits
// RULE_18: answers write address d2, read d3
// RULE_19: block read returns count, then indexed bytes
// RULE_20: byte 0 low nibble register frequency code
`timescale 1ns/1ns
`default_nettype none

module cgr_smbus_regs #(
  parameter logic [7:0] PART_CODE     = 8'h5a, // arbitrary value
  parameter logic [3:0] REVISION_CODE = 4'h0,  // arbitrary value
  parameter logic [3:0] MAKER_CODE    = 4'h6   // arbitrary value
) (
  input  wire logic        MCLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic        SMB_CLK_IN,
  input  wire logic        SMB_DATA_IN,
  output var  logic        SMB_DATA_OUT,
  output var  logic        SMB_DATA_OE_OUT,
  input  wire logic [2:0]  FREQ_STRAP_IN,
  input  wire logic        SPREAD_PIN_IN,
  input  wire logic        POWERDOWN_PIN_N_IN,
  output var  logic [3:0]  FREQ_CODE_OUT,
  output var  logic        CPU_SPREAD_ON_OUT,
  output var  logic        SRC_SPREAD_ON_OUT,
  output var  logic [3:0]  BUS33_CLOCK_EN_OUT,
  output var  logic [3:0]  LINK66_CLOCK_EN_OUT,
  output var  logic [1:0]  USB_CLOCK_EN_OUT,
  output var  logic [1:0]  CRYSTAL_COPY_EN_OUT,
  output var  logic [3:0]  PROCESSOR_PAIR_EN_OUT,
  output var  logic        SERIAL_REF_PAIR_HIZ_OUT,
  output var  logic [1:0]  USB_CLOCK_STRENGTH_OUT,
  output var  logic [1:0]  SERIAL_REF_FREQ_CODE_OUT,
  output var  logic [10:0] CPU_VCO_MULT_OUT,
  output var  logic [6:0]  CPU_VCO_DIV_OUT,
  output var  logic [10:0] SRC_VCO_MULT_OUT,
  output var  logic [6:0]  SRC_VCO_DIV_OUT,
  output var  logic [14:0] CPU_SPREAD_PERCENT_OUT
);
  import cgr_pkg::*;

  logic [7:0]  regs [NUM_BYTES];
  logic        clk_meta;
  logic        clk_sync;
  logic        clk_prev;
  logic        dat_meta;
  logic        dat_sync;
  logic        dat_prev;
  logic [2:0]  fs_meta;
  logic [2:0]  fs_sync;
  logic        spr_meta;
  logic        spr_sync;
  logic        pd_meta_n;
  logic        pd_sync_n;
  logic [1:0]  strap_cnt;
  logic        strap_done;
  logic [2:0]  latched_fs;
  logic        strap_load;
  cgr_state_t  state;
  cgr_phase_t  phase;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  logic [7:0]  tx_shift;
  logic [7:0]  index;
  logic [7:0]  left;
  logic        reading;
  logic        host_ack;
  logic        data_oe;
  logic        clk_rise;
  logic        clk_fall;
  logic        start_seen;
  logic        stop_seen;
  logic        byte_end;
  logic        wr_fire;
  logic [7:0]  rd_byte;
  logic [3:0]  sel_code;
  logic [15:0] cpu_rom;
  logic [15:0] src_rom;
  logic [9:0]  cpu_n;
  logic [5:0]  cpu_m;
  logic [9:0]  src_n;
  logic [5:0]  src_m;

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      clk_meta <= 1'b1;
      clk_sync <= 1'b1;
      clk_prev <= 1'b1;
      dat_meta <= 1'b1;
      dat_sync <= 1'b1;
      dat_prev <= 1'b1;
    end else begin
      clk_meta <= SMB_CLK_IN;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
      dat_meta <= SMB_DATA_IN;
      dat_sync <= dat_meta;
      dat_prev <= dat_sync;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      fs_meta   <= 3'h0;
      fs_sync   <= 3'h0;
      spr_meta  <= 1'b0;
      spr_sync  <= 1'b0;
      pd_meta_n <= 1'b1;
      pd_sync_n <= 1'b1;
    end else begin
      fs_meta   <= FREQ_STRAP_IN;
      fs_sync   <= fs_meta;
      spr_meta  <= SPREAD_PIN_IN;
      spr_sync  <= spr_meta;
      pd_meta_n <= POWERDOWN_PIN_N_IN;
      pd_sync_n <= pd_meta_n;
    end
  end

  // straps are caught once, after the synchronisers have filled
  assign strap_load = (strap_cnt == STRAP_SETTLE) && !strap_done;

  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
      latched_fs <= 3'h0;
    end else if (strap_load) begin
      strap_done <= 1'b1;
      latched_fs <= fs_sync; // RULE_01
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 2'h1;
    end
  end

  assign clk_rise   = clk_sync && !clk_prev;
  assign clk_fall   = !clk_sync && clk_prev;
  assign start_seen = clk_sync && clk_prev && dat_prev && !dat_sync;
  assign stop_seen  = clk_sync && clk_prev && !dat_prev && dat_sync;
  assign byte_end   = (state == ST_RX) && clk_fall && (bit_cnt == 4'h8);
  // writes past the byte count are acknowledged but dropped
  assign wr_fire    = byte_end && (phase == PH_DATA) && (left != 8'h00);

  always_comb begin
    rd_byte = 8'h00;
    if (index < 8'(NUM_BYTES)) begin
      rd_byte = regs[index[4:0]];
    end
  end

  // serial engine: bytes framed by scl edges seen on the system clock
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      state    <= ST_IDLE;
      phase    <= PH_ADDR;
      bit_cnt  <= 4'h0;
      shift    <= 8'h00;
      tx_shift <= 8'h00;
      index    <= 8'h00;
      left     <= 8'h00;
      reading  <= 1'b0;
      host_ack <= 1'b0;
      data_oe  <= 1'b0;
    end else if (start_seen) begin
      state   <= ST_RX;
      phase   <= PH_ADDR;
      bit_cnt <= 4'h0;
      reading <= 1'b0;
      data_oe <= 1'b0;
    end else if (stop_seen) begin
      state   <= ST_IDLE;
      data_oe <= 1'b0;
    end else begin
      case (state)
        ST_RX: begin
          if (clk_rise) begin
            shift   <= {shift[6:0], dat_sync};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_end) begin
            bit_cnt <= 4'h0;
            state   <= ST_RX_ACK;
            data_oe <= 1'b1;
            case (phase)
              PH_ADDR: begin
                if (shift == ADDR_WRITE) begin // RULE_18
                  phase <= PH_INDEX;
                end else if (shift == ADDR_READ) begin // RULE_18
                  reading <= 1'b1;
                end else begin
                  // foreign address: stay off the line
                  state   <= ST_IDLE;
                  data_oe <= 1'b0;
                end
              end
              PH_INDEX: begin
                index <= shift;
                phase <= PH_COUNT;
              end
              PH_COUNT: begin
                left  <= shift;
                phase <= PH_DATA;
              end
              default: begin
                if (left != 8'h00) begin
                  left  <= left - 8'h01;
                  index <= index + 8'h01;
                end
              end
            endcase
          end
        end
        ST_RX_ACK: begin
          if (clk_fall) begin
            if (reading) begin
              // count goes first, then the indexed bytes
              tx_shift <= regs[REG_READ_LEN[4:0]]; // RULE_19
              data_oe  <= !regs[REG_READ_LEN[4:0]][7];
              state    <= ST_TX;
            end else begin
              data_oe <= 1'b0;
              state   <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (clk_fall) begin
            if (bit_cnt == 4'h7) begin
              bit_cnt  <= 4'h0;
              data_oe  <= 1'b0;
              host_ack <= 1'b0;
              state    <= ST_TX_ACK;
            end else begin
              bit_cnt  <= bit_cnt + 4'h1;
              tx_shift <= {tx_shift[6:0], 1'b0};
              data_oe  <= !tx_shift[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (clk_rise) begin
            if (dat_sync) begin
              state <= ST_IDLE; // RULE_19
            end else begin
              host_ack <= 1'b1;
            end
          end else if (clk_fall && host_ack) begin
            tx_shift <= rd_byte; // RULE_19
            data_oe  <= !rd_byte[7];
            index    <= index + 8'h01;
            state    <= ST_TX;
          end
        end
        default: begin
          data_oe <= 1'b0;
        end
      endcase
    end
  end

  function automatic logic [7:0] reset_value(input int i);
    case (i)
      0:       reset_value = RST_FREQ_SPREAD; // RULE_01 RULE_02
      1, 2:    reset_value = RST_OUTPUT_ON; // RULE_03
      3:       reset_value = RST_SRC_CTRL; // RULE_04 RULE_05
      6:       reset_value = PART_CODE; // RULE_08
      7:       reset_value = {REVISION_CODE, MAKER_CODE}; // RULE_09
      8:       reset_value = RST_READ_LEN; // RULE_10
      default: reset_value = RST_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] write_mask(input int i);
    case (i)
      6, 7:    write_mask = MASK_NONE; // RULE_08 RULE_09
      14:      write_mask = MASK_SPREAD_HIGH; // RULE_15
      default: write_mask = MASK_ALL;
    endcase
  endfunction

  function automatic logic [7:0] div_high(input logic [15:0] rom);
    // table holds n in bits 15:6, so n bit 8 is rom bit 14 and n bit 9 is rom bit 15
    div_high = {rom[14], rom[15], rom[5:0]};
  endfunction

  // one generated byte register per index
  for (genvar g = 0; g < NUM_BYTES; g++) begin : g_byte
    always_ff @(posedge MCLK_IN) begin
      if (!NRST_IN) begin
        regs[g] <= reset_value(g);
      end else if (strap_load && g == 0) begin
        regs[g] <= {regs[g][7:3], fs_sync}; // RULE_20
      end else if (strap_load && (g == 11 || g == 15)) begin
        regs[g] <= div_high(g == 11 ? CPU_ROM[fs_sync] : SRC_ROM[fs_sync]); // RULE_14 RULE_16
      end else if (strap_load && (g == 12 || g == 16)) begin
        regs[g] <= (g == 12) ? CPU_ROM[fs_sync][13:6] : SRC_ROM[fs_sync][13:6]; // RULE_14
      end else if (wr_fire && index == 8'(g)) begin
        regs[g] <= (shift & write_mask(g)) | (regs[g] & ~write_mask(g));
      end
    end
  end

  assign sel_code = regs[0][BIT_SELECT_ORIGIN] ? regs[0][3:0]
                                               : {1'b0, latched_fs}; // RULE_01 RULE_20
  // table covers the low three code bits only
  assign cpu_rom  = CPU_ROM[sel_code[2:0]];
  assign src_rom  = SRC_ROM[sel_code[2:0]];

  always_comb begin
    cpu_n = cpu_rom[15:6];
    cpu_m = cpu_rom[5:0];
    src_n = src_rom[15:6];
    src_m = src_rom[5:0];
    if (regs[REG_DIV_GATE[4:0]][BIT_MN_ENABLE]) begin // RULE_11
      cpu_n = {regs[11][BIT_FEEDBACK_DIVIDER_MSB], regs[11][BIT_N_DIV8], regs[12]}; // RULE_12
      cpu_m = regs[11][5:0]; // RULE_12
      src_n = {regs[15][BIT_FEEDBACK_DIVIDER_MSB], regs[15][BIT_N_DIV8], regs[16]}; // RULE_16 RULE_17
      src_m = regs[15][5:0]; // RULE_16
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      SMB_DATA_OUT    <= 1'b0;
      SMB_DATA_OE_OUT <= 1'b0;
    end else begin
      SMB_DATA_OUT    <= 1'b0;
      SMB_DATA_OE_OUT <= data_oe; // RULE_18
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      FREQ_CODE_OUT     <= 4'h0;
      CPU_SPREAD_ON_OUT <= 1'b0;
      SRC_SPREAD_ON_OUT <= 1'b0;
    end else begin
      FREQ_CODE_OUT     <= sel_code; // RULE_01
      CPU_SPREAD_ON_OUT <= regs[0][BIT_CPU_SPREAD] || spr_sync; // RULE_02
      SRC_SPREAD_ON_OUT <= regs[0][BIT_SRC_SPREAD] || spr_sync; // RULE_02
    end
  end

  // the pad drivers hold disabled ends low; processor pair true low, complement high
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      BUS33_CLOCK_EN_OUT    <= 4'hf;
      LINK66_CLOCK_EN_OUT   <= 4'hf;
      USB_CLOCK_EN_OUT      <= 2'h3;
      CRYSTAL_COPY_EN_OUT   <= 2'h3;
      PROCESSOR_PAIR_EN_OUT <= 4'hf;
    end else begin
      BUS33_CLOCK_EN_OUT    <= regs[1][7:4]; // RULE_03
      LINK66_CLOCK_EN_OUT   <= regs[1][3:0]; // RULE_03
      USB_CLOCK_EN_OUT      <= regs[2][7:6]; // RULE_03
      CRYSTAL_COPY_EN_OUT   <= regs[2][5:4]; // RULE_03
      PROCESSOR_PAIR_EN_OUT <= regs[2][3:0]; // RULE_03
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      SERIAL_REF_PAIR_HIZ_OUT  <= 1'b0;
      USB_CLOCK_STRENGTH_OUT   <= 2'h0;
      SERIAL_REF_FREQ_CODE_OUT <= 2'h0;
      CPU_SPREAD_PERCENT_OUT   <= 15'h0000;
    end else begin
      SERIAL_REF_PAIR_HIZ_OUT  <= !regs[3][BIT_SRC_ENABLE] // RULE_05
                                  || (!pd_sync_n && regs[3][BIT_SRC_PD_MODE]); // RULE_04
      USB_CLOCK_STRENGTH_OUT   <= regs[4][1:0]; // RULE_06
      SERIAL_REF_FREQ_CODE_OUT <= regs[5][3:2]; // RULE_07
      CPU_SPREAD_PERCENT_OUT   <= {regs[14][6:0], regs[13]}; // RULE_15
    end
  end

  // multiplier and divider terms for the analog loops
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      CPU_VCO_MULT_OUT <= N_OFFSET;
      CPU_VCO_DIV_OUT  <= M_OFFSET;
      SRC_VCO_MULT_OUT <= N_OFFSET;
      SRC_VCO_DIV_OUT  <= M_OFFSET;
    end else begin
      CPU_VCO_MULT_OUT <= {1'b0, cpu_n} + N_OFFSET; // RULE_13
      CPU_VCO_DIV_OUT  <= {1'b0, cpu_m} + M_OFFSET; // RULE_13
      SRC_VCO_MULT_OUT <= {1'b0, src_n} + N_OFFSET; // RULE_13
      SRC_VCO_DIV_OUT  <= {1'b0, src_m} + M_OFFSET; // RULE_13
    end
  end

endmodule

`default_nettype wire

// File: tb/cgr_smbus_host.sv
`timescale 1ns/1ns
`default_nettype none
module cgr_smbus_host (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_pull_out
);
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  // ten system clocks per phase clears the eight-cycle minimum
  task automatic half();
    repeat (10) @(posedge clk_in);
    #1;
  endtask
  // data moves only mid-low phase, never near a clock edge
  task automatic clk_bit(input logic b, output logic s);
    half();
    sda_pull_out = !b;
    half();
    scl_out = 1'b1;
    half();
    s = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic start();
    half();
    sda_pull_out = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    sda_pull_out = 1'b1;
    half();
    scl_out = 1'b0;
  endtask
  task automatic stop();
    half();
    sda_pull_out = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    sda_pull_out = 1'b0;
    half();
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  // last byte gets a not-acknowledge to end the read
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
    clk_bit(last, s);
  endtask
endmodule
`default_nettype wire

// File: tb/cgr_smbus_regs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module cgr_smbus_regs_chk (
  input wire logic        MCLK_IN,
  input wire logic        NRST_IN,
  input wire logic        SMB_CLK_IN,
  input wire logic        SMB_DATA_OUT,
  input wire logic        SMB_DATA_OE_OUT,
  input wire logic        SPREAD_PIN_IN,
  input wire logic        POWERDOWN_PIN_N_IN,
  input wire logic [3:0]  FREQ_CODE_OUT,
  input wire logic        CPU_SPREAD_ON_OUT,
  input wire logic        SRC_SPREAD_ON_OUT,
  input wire logic [3:0]  BUS33_CLOCK_EN_OUT,
  input wire logic [3:0]  PROCESSOR_PAIR_EN_OUT,
  input wire logic        SERIAL_REF_PAIR_HIZ_OUT,
  input wire logic [10:0] CPU_VCO_MULT_OUT,
  input wire logic [6:0]  CPU_VCO_DIV_OUT,
  input wire logic [10:0] SRC_VCO_MULT_OUT,
  input wire logic [6:0]  SRC_VCO_DIV_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!NRST_IN);
  // five cycles covers two sync flops plus the output flop
  sequence s_pin_held;
    SPREAD_PIN_IN [*5];
  endsequence
  sequence s_float_awake;
    POWERDOWN_PIN_N_IN [*5] ##0 $rose(SERIAL_REF_PAIR_HIZ_OUT);
  endsequence
  property p_spread_force;
    s_pin_held |-> CPU_SPREAD_ON_OUT && SRC_SPREAD_ON_OUT;
  endproperty
  // register bytes 1, 2 only change after a bit is taken, so clock is low
  property p_en_change;
    $changed({BUS33_CLOCK_EN_OUT, PROCESSOR_PAIR_EN_OUT}) |-> !SMB_CLK_IN;
  endproperty
  property p_float_by_write;
    s_float_awake |-> !SMB_CLK_IN;
  endproperty
  property p_code_msb;
    $changed(FREQ_CODE_OUT[3]) |-> !SMB_CLK_IN;
  endproperty
  // past the strap catch, divider terms move only by a byte write or a code change
  property p_cpu_vco;
    $changed({CPU_VCO_MULT_OUT, CPU_VCO_DIV_OUT}) && $stable(FREQ_CODE_OUT) |-> !SMB_CLK_IN;
  endproperty
  property p_src_vco;
    $changed({SRC_VCO_MULT_OUT, SRC_VCO_DIV_OUT}) && $stable(FREQ_CODE_OUT) |-> !SMB_CLK_IN;
  endproperty
  property p_data_low;
    SMB_DATA_OUT == 1'b0;
  endproperty
  property p_ack_scl_low;
    $changed(SMB_DATA_OE_OUT) |-> !SMB_CLK_IN;
  endproperty
  a_spread_force: assert property (p_spread_force)
    else $error("spread pin not forcing spread");
  a_en_change: assert property (p_en_change)
    else $error("enable moved with bus clock high");
  a_float_by_write: assert property (p_float_by_write)
    else $error("pair floated without write or powerdown");
  a_code_msb: assert property (p_code_msb)
    else $error("frequency code msb moved with bus clock high");
  a_cpu_vco: assert property (p_cpu_vco)
    else $error("processor vco terms moved with bus clock high");
  a_src_vco: assert property (p_src_vco)
    else $error("serial vco terms moved with bus clock high");
  a_data_low: assert property (p_data_low)
    else $error("data output not held low");
  a_ack_scl_low: assert property (p_ack_scl_low)
    else $error("data pull moved with bus clock high");
endmodule

bind cgr_smbus_regs cgr_smbus_regs_chk u_chk (
  .MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN), .SMB_CLK_IN(SMB_CLK_IN),
  .SMB_DATA_OUT(SMB_DATA_OUT), .SMB_DATA_OE_OUT(SMB_DATA_OE_OUT),
  .SPREAD_PIN_IN(SPREAD_PIN_IN), .POWERDOWN_PIN_N_IN(POWERDOWN_PIN_N_IN),
  .FREQ_CODE_OUT(FREQ_CODE_OUT), .CPU_SPREAD_ON_OUT(CPU_SPREAD_ON_OUT),
  .SRC_SPREAD_ON_OUT(SRC_SPREAD_ON_OUT), .BUS33_CLOCK_EN_OUT(BUS33_CLOCK_EN_OUT),
  .PROCESSOR_PAIR_EN_OUT(PROCESSOR_PAIR_EN_OUT),
  .SERIAL_REF_PAIR_HIZ_OUT(SERIAL_REF_PAIR_HIZ_OUT),
  .CPU_VCO_MULT_OUT(CPU_VCO_MULT_OUT), .CPU_VCO_DIV_OUT(CPU_VCO_DIV_OUT),
  .SRC_VCO_MULT_OUT(SRC_VCO_MULT_OUT), .SRC_VCO_DIV_OUT(SRC_VCO_DIV_OUT));
`default_nettype wire

// File: tb/test_cgr_smbus_regs.sv
`timescale 1ns/1ns
`default_nettype none
module test_cgr_smbus_regs;
  import cgr_pkg::*;
  localparam logic [7:0] PC  = 8'h3c; // arbitrary value
  localparam logic [3:0] REV = 4'h2;  // arbitrary value
  localparam logic [3:0] MK  = 4'h9;  // arbitrary value
  logic        clk    = 1'b0;
  logic        nrst   = 1'b0;
  logic        spread = 1'b0;
  logic        pd_n   = 1'b1;
  logic [2:0]  strap  = 3'h5;
  logic [7:0]  r      = 8'h53;
  logic        scl, pull, oe, dout, cspr, sspr, hiz, a;
  logic [3:0]  fcode, bus_en, link_en, cpu_en;
  logic [1:0]  usb_en, ref_en, strg, sfc;
  logic [10:0] cmul, smul;
  logic [6:0]  cdiv, sdiv;
  logic [14:0] spct;
  logic [7:0]  m [0:16];
  logic [7:0]  wb [0:6];
  logic [7:0]  rb [0:9];
  int          n_fail = 0;
  int          checks = 0;
  int          base, cnt;
  wire logic   sda = !(pull | oe);

  always #25 clk = ~clk;
  cgr_smbus_host h (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));
  cgr_smbus_regs #(.PART_CODE(PC), .REVISION_CODE(REV), .MAKER_CODE(MK)) dut (
    .MCLK_IN(clk), .NRST_IN(nrst), .SMB_CLK_IN(scl), .SMB_DATA_IN(sda),
    .SMB_DATA_OUT(dout), .SMB_DATA_OE_OUT(oe), .FREQ_STRAP_IN(strap),
    .SPREAD_PIN_IN(spread), .POWERDOWN_PIN_N_IN(pd_n), .FREQ_CODE_OUT(fcode),
    .CPU_SPREAD_ON_OUT(cspr), .SRC_SPREAD_ON_OUT(sspr), .BUS33_CLOCK_EN_OUT(bus_en),
    .LINK66_CLOCK_EN_OUT(link_en), .USB_CLOCK_EN_OUT(usb_en),
    .CRYSTAL_COPY_EN_OUT(ref_en), .PROCESSOR_PAIR_EN_OUT(cpu_en),
    .SERIAL_REF_PAIR_HIZ_OUT(hiz), .USB_CLOCK_STRENGTH_OUT(strg),
    .SERIAL_REF_FREQ_CODE_OUT(sfc), .CPU_VCO_MULT_OUT(cmul), .CPU_VCO_DIV_OUT(cdiv),
    .SRC_VCO_MULT_OUT(smul), .SRC_VCO_DIV_OUT(sdiv), .CPU_SPREAD_PERCENT_OUT(spct));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] hi_of(input logic [15:0] rom);
    return {rom[14], rom[15], rom[5:0]};
  endfunction
  function automatic logic [15:0] pick(input logic [15:0] rom, input logic [7:0] hi, lo);
    return m[10][7] ? {hi[6], hi[7], lo, hi[5:0]} : rom;
  endfunction
  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] idx, input int n);
    logic ok, ak;
    h.start();
    h.put_byte(ADDR_WRITE, ok);
    h.put_byte(idx, ak);
    ok = ok & ak;
    h.put_byte(8'(n), ak);
    ok = ok & ak;
    for (int i = 0; i < n; i++) begin
      h.put_byte(wb[i], ak);
      ok = ok & ak;
    end
    h.stop();
    chk(ok, 1'b1);
  endtask
  task automatic rd(input logic [7:0] idx, input int n);
    logic ok, ak;
    h.start();
    h.put_byte(ADDR_WRITE, ok);
    h.put_byte(idx, ak);
    ok = ok & ak;
    h.start();
    h.put_byte(ADDR_READ, ak);
    ok = ok & ak;
    h.get_byte(1'b0, rb[0]);
    for (int i = 1; i <= n; i++) h.get_byte(i == n, rb[i]);
    h.stop();
    chk(ok, 1'b1);
  endtask
  task automatic chk_out();
    logic [3:0]  fc;
    logic [15:0] c, s;
    fc = m[0][7] ? m[0][3:0] : {1'b0, strap};
    c = pick(CPU_ROM[fc[2:0]], m[11], m[12]);
    s = pick(SRC_ROM[fc[2:0]], m[15], m[16]);
    chk(fcode, fc);
    chk({cspr, sspr}, {m[0][6] | spread, m[0][5] | spread});
    chk({bus_en, link_en, usb_en, ref_en, cpu_en}, {m[1], m[2]});
    chk(hiz, !m[3][0] | (!pd_n & m[3][1]));
    chk(strg, m[4][1:0]);
    chk(sfc, m[5][3:2]);
    chk(spct, {m[14][6:0], m[13]});
    chk({cmul, cdiv}, {c[15:6] + 11'h008, c[5:0] + 7'h02});
    chk({smul, sdiv}, {s[15:6] + 11'h008, s[5:0] + 7'h02});
  endtask

  initial begin
    for (int i = 0; i < 17; i++) m[i] = 8'h00;
    m[0] = {5'h00, strap};
    m[1] = 8'hff;
    m[2] = 8'hff;
    m[3] = 8'h01;
    m[6] = PC;
    m[7] = {REV, MK};
    m[8] = 8'h09;
    m[11] = hi_of(CPU_ROM[strap]);
    m[12] = CPU_ROM[strap][13:6];
    m[15] = hi_of(SRC_ROM[strap]);
    m[16] = SRC_ROM[strap][13:6];
    tick(2);
    nrst = 1'b1;
    tick(12);
    chk_out();
    rd(8'h00, 9);
    chk(rb[0], 8'h09);
    for (int i = 0; i < 9; i++) chk(rb[i + 1], m[i]);
    rd(8'h0b, 6);
    for (int i = 1; i <= 6; i++) chk(rb[i], m[i + 10]);
    wb[0] = ~PC;
    wb[1] = ~{REV, MK};
    wr(8'h06, 2);
    rd(8'h06, 2);
    chk(rb[1], PC);
    chk(rb[2], {REV, MK});
    wb[0] = 8'h03;
    wr(8'h08, 1);
    rd(8'h00, 3);
    chk(rb[0], 8'h03);
    wb[0] = 8'h09;
    wr(8'h08, 1);
    h.start();
    h.put_byte(8'hd4, a);
    h.stop();
    chk(a, 1'b0);
    // all-zero and all-one passes first, then random contents
    for (int k = 0; k < 8; k++) begin
      base = k[0] ? 10 : 0;
      cnt = k[0] ? 7 : 6;
      for (int i = 0; i < cnt; i++) begin
        r = lfsr(r);
        wb[i] = k < 2 ? 8'h00 : k < 4 ? 8'hff : r;
        m[base + i] = base + i == 14 ? wb[i] & 8'h7f : wb[i];
      end
      wr(8'(base), cnt);
      r = lfsr(r);
      spread = r[0];
      pd_n = r[1];
      tick(6);
      chk_out();
      rd(8'(base), cnt);
      for (int i = 0; i < cnt; i++) chk(rb[i + 1], m[base + i]);
      pd_n = 1'b1;
      spread = 1'b0;
    end
    close_out();
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
